// >>> src/e1pm_pkg.sv
/*
  Shared constants and carrier types for the E1 performance-monitor block:
  register indices, field positions, counter widths, the APB request bundle
  and the block's registered state.
  Assumes an APB master with 32-bit data and one register per aligned word.
*/
package e1pm_pkg;

  // Register indices; byte address is four times the index
  localparam logic [9:0] IDX_VIOL_HI     = 10'h000;
  localparam logic [9:0] IDX_VIOL_LO     = 10'h001;
  localparam logic [9:0] IDX_CRC_HI      = 10'h002;
  localparam logic [9:0] IDX_CRC_LO      = 10'h003;
  localparam logic [9:0] IDX_EBIT_HI     = 10'h004;
  localparam logic [9:0] IDX_EBIT_LO     = 10'h005;
  localparam logic [9:0] IDX_ALARM_MASK  = 10'h016;
  localparam logic [9:0] IDX_TIMING_MASK = 10'h017;
  localparam logic [9:0] IDX_CTRL        = 10'h018;

  // Control register field positions
  localparam int CTRL_SHORT_INTERVAL = 7;
  localparam int CTRL_CODE_VIOLATION = 6;
  localparam int CTRL_HDB3_ENABLE    = 2;

  // Alarm mask bit positions
  localparam int AM_SIGNALING_ONES   = 7;
  localparam int AM_DISTANT_MF       = 6;
  localparam int AM_SIGNALING_ZEROS  = 5;
  localparam int AM_RX_SLIP          = 4;
  localparam int AM_UNFRAMED_ONES    = 3;
  localparam int AM_REMOTE_ALARM     = 2;
  localparam int AM_CARRIER_LOSS     = 1;
  localparam int AM_SYNC_LOSS        = 0;

  // Timing mask bit positions
  localparam int TM_RX_SIG_MF        = 7;
  localparam int TM_RX_ALIGN         = 6;
  localparam int TM_TX_MF            = 5;
  localparam int TM_SECOND_TICK      = 4;
  localparam int TM_TX_ALIGN         = 3;
  localparam int TM_TX_CLOCK_LOSS    = 2;
  localparam int TM_RX_CRC_MF        = 1;
  localparam int TM_TX_SLIP          = 0;

  // Reset values
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h00;

  // Line input bit positions inside the synchroniser vectors
  localparam int LN_CLK = 2;
  localparam int LN_POS = 1;
  localparam int LN_NEG = 0;

  // APB request from the master
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } e1pm_apb_t;

  // All registered state of the block
  typedef struct packed {
    logic [7:0]  alarm_mask;
    logic [7:0]  timing_mask;
    logic [7:0]  ctrl;
    logic [15:0] viol_live;
    logic [15:0] viol_snap;
    logic [9:0]  crc_live;
    logic [9:0]  crc_snap;
    logic [11:0] fas_live;
    logic [11:0] fas_snap;
    logic [9:0]  ebit_live;
    logic [9:0]  ebit_snap;
    logic [2:0]  sync1;
    logic [2:0]  sync2;
    logic [2:0]  sync3;
    logic [2:0]  stable;
    logic        have_mark;
    logic        last_mark_pos;
    logic [1:0]  zero_run;
    logic        have_bpv;
    logic        last_bpv_pos;
    logic        tick;
    logic        irq;
    logic [31:0] rdata;
  } e1pm_state_t;

endpackage

// >>> src/e1pm_counters.sv
/*
  E1 performance monitor: violation, CRC4, E-bit and FAS word error counters
  snapshotted on the interval tick, plus the two interrupt mask registers,
  all reached over APB.
  Assumes the framer supplies the one-second and 62.5 ms tick pulses, the
  sync-loss levels, per-word error pulses and the raw status event levels,
  all on ref_clk; the receive line clock and rails are asynchronous pins.
*/
// Our own choice: register access over APB.
// How it works
// R1: Mask bit zero blocks its status event from the interrupt request; one passes it.
// R2: Alarm mask 7..0: sig_ones, dist_mf, sig_zeros, rx_slip, unframed, remote, carrier, sync.
// R3: Timing mask 7..0: rx_mf, rx_align, tx_mf, tick, tx_align, tx_clk, crc_mf, tx_slip.
// R4: Four counters: line violations, CRC4 word errors, far-end E bits, FAS word errors.
// R5: All snapshots update together each interval: one second, or 62.5 ms if short selected.
// R6: Snapshot boundary is the very tick that drives the timer status flag output.
// R7: Host reads counters before the next boundary, else previous values are overwritten.
// R8: Every counter stops at its maximum and never wraps to zero.
// R9: Violation count is 16 bits: high byte at index 00, low byte at 01.
// R10: With code violation select clear, count same-polarity consecutive marks.
// R11: In that mode with HDB3 decoding, substitution violations are not counted.
// R12: With code violation select set, count consecutive same-polarity bipolar violations.
// R13: Software picks bipolar mode for AMI lines and code violation mode for HDB3.
// R14: Violation counter runs even during sync loss and saturates at 65535.
// R15: CRC4 count is 10 bits: top bits in index 02 bits 1:0, low byte at 03.
// R16: CRC4 counting pauses on frame or CRC4 multiframe sync loss, not CAS loss.
// R17: Index 02 bits 7:2 return the top six bits of the 12-bit FAS count.
// R18: Counter registers are read-only snapshots; live totals restart at each boundary.
module e1pm_counters (
  // Clock and reset
  input  wire logic                ref_clk,
  input  wire logic                rst_n,
  // APB slave
  input  wire e1pm_pkg::e1pm_apb_t apb_i,
  output logic [31:0]              prdata,
  output logic                     pready,
  output logic                     pslverr,
  // Receive line pins, asynchronous
  input  wire logic                rx_line_clk,
  input  wire logic                rx_pos,
  input  wire logic                rx_neg,
  // Framer timer ticks and sync levels
  input  wire logic                tick_one_second,
  input  wire logic                tick_short,
  input  wire logic                frame_sync_loss,
  input  wire logic                crc_mf_sync_loss,
  // Framer word error pulses
  input  wire logic                crc_word_error,
  input  wire logic                fas_word_error,
  input  wire logic                ebit_error,
  // Framer status events
  input  wire logic [7:0]          alarm_status,
  input  wire logic [7:0]          timing_status,
  // Outputs to the framer
  output logic                     timer_status_flag,
  output logic                     irq_request,
  output logic                     short_interval_select,
  output logic                     code_violation_select,
  output logic                     receive_hdb3_enable
);

  e1pm_pkg::e1pm_state_t s_ff;
  e1pm_pkg::e1pm_state_t nxt_s;

  logic       setup;
  logic       access;
  logic       hit;
  logic [9:0] idx;
  logic [7:0] rd_mux;
  logic       boundary;
  logic       bit_stb;
  logic       mark;
  logic       pol_pos;
  logic       bpv;
  logic       hdb3_sub;
  logic       cv;
  logic       viol_inc;
  logic       crc_inc;
  logic       fas_inc;

  // Bus phase and address decode
  assign setup  = apb_i.psel & ~apb_i.penable;
  assign access = apb_i.psel & apb_i.penable;
  assign idx    = apb_i.paddr[11:2];

  // Read mux; unmapped words answer an error
  always_comb begin
    hit    = (apb_i.paddr[1:0] == 2'b00);
    rd_mux = 8'h00;
    case (idx)
      e1pm_pkg::IDX_VIOL_HI:     rd_mux = s_ff.viol_snap[15:8];                     // R9
      e1pm_pkg::IDX_VIOL_LO:     rd_mux = s_ff.viol_snap[7:0];                      // R9
      e1pm_pkg::IDX_CRC_HI:      rd_mux = {s_ff.fas_snap[11:6], s_ff.crc_snap[9:8]}; // R15 R17
      e1pm_pkg::IDX_CRC_LO:      rd_mux = s_ff.crc_snap[7:0];                       // R15
      e1pm_pkg::IDX_EBIT_HI:     rd_mux = {s_ff.fas_snap[5:0], s_ff.ebit_snap[9:8]};
      e1pm_pkg::IDX_EBIT_LO:     rd_mux = s_ff.ebit_snap[7:0];
      e1pm_pkg::IDX_ALARM_MASK:  rd_mux = s_ff.alarm_mask;
      e1pm_pkg::IDX_TIMING_MASK: rd_mux = s_ff.timing_mask;
      e1pm_pkg::IDX_CTRL:        rd_mux = s_ff.ctrl;
      default:                   hit    = 1'b0;
    endcase
  end

  // Interval boundary is the selected timer tick
  assign boundary = s_ff.ctrl[e1pm_pkg::CTRL_SHORT_INTERVAL] ? tick_short
                                                              : tick_one_second; // R5 R6

  // Line bit strobe on a settled rising edge of the line clock
  assign bit_stb = s_ff.sync2[e1pm_pkg::LN_CLK] & s_ff.sync3[e1pm_pkg::LN_CLK]
                 & ~s_ff.stable[e1pm_pkg::LN_CLK];
  assign pol_pos = s_ff.stable[e1pm_pkg::LN_POS];
  assign mark    = bit_stb & (s_ff.stable[e1pm_pkg::LN_POS] | s_ff.stable[e1pm_pkg::LN_NEG]);

  // Violation classification
  assign bpv      = mark & s_ff.have_mark & (pol_pos == s_ff.last_mark_pos);           // R10
  assign hdb3_sub = bpv & s_ff.ctrl[e1pm_pkg::CTRL_HDB3_ENABLE] & (s_ff.zero_run == 2'd2); // R11
  assign cv       = bpv & s_ff.have_bpv & (pol_pos == s_ff.last_bpv_pos);              // R12
  assign viol_inc = s_ff.ctrl[e1pm_pkg::CTRL_CODE_VIOLATION] ? cv : (bpv & ~hdb3_sub); // R10 R12 R14

  // Gated error events
  assign crc_inc = crc_word_error & ~frame_sync_loss & ~crc_mf_sync_loss; // R16
  assign fas_inc = fas_word_error & ~frame_sync_loss;

  // Next-state logic
  always_comb begin
    nxt_s = s_ff;

    // Three-stage pin synchronisers; a level settles when stages two and three agree
    nxt_s.sync1 = {rx_line_clk, rx_pos, rx_neg};
    nxt_s.sync2 = s_ff.sync1;
    nxt_s.sync3 = s_ff.sync2;
    for (int i = 0; i < 3; i++) begin
      if (s_ff.sync2[i] == s_ff.sync3[i]) begin
        nxt_s.stable[i] = s_ff.sync3[i];
      end
    end

    // Mark polarity history and zero run for HDB3 recognition
    if (bit_stb) begin
      if (mark) begin
        nxt_s.have_mark     = 1'b1;
        nxt_s.last_mark_pos = pol_pos;
        nxt_s.zero_run      = 2'd0;
      end else if (s_ff.zero_run != 2'd2) begin
        nxt_s.zero_run = s_ff.zero_run + 2'd1;
      end
    end
    if (bpv) begin
      nxt_s.have_bpv     = 1'b1;
      nxt_s.last_bpv_pos = pol_pos;
    end

    // Live counters saturate; on the boundary they restart and snapshots latch
    if (boundary) begin
      nxt_s.viol_snap = s_ff.viol_live; // R4 R5 R18
      nxt_s.crc_snap  = s_ff.crc_live;  // R4 R5 R18
      nxt_s.fas_snap  = s_ff.fas_live;  // R4 R5 R18
      nxt_s.ebit_snap = s_ff.ebit_live; // R4 R5 R18
      nxt_s.viol_live = {15'h0000, viol_inc};
      nxt_s.crc_live  = {9'h000, crc_inc};
      nxt_s.fas_live  = {11'h000, fas_inc};
      nxt_s.ebit_live = {9'h000, ebit_error};
    end else begin
      if (viol_inc && !(&s_ff.viol_live)) begin
        nxt_s.viol_live = s_ff.viol_live + 16'h0001; // R8 R14
      end
      if (crc_inc && !(&s_ff.crc_live)) begin
        nxt_s.crc_live = s_ff.crc_live + 10'h001; // R8
      end
      if (fas_inc && !(&s_ff.fas_live)) begin
        nxt_s.fas_live = s_ff.fas_live + 12'h001; // R8
      end
      if (ebit_error && !(&s_ff.ebit_live)) begin
        nxt_s.ebit_live = s_ff.ebit_live + 10'h001; // R8
      end
    end
    nxt_s.tick = boundary; // R6

    // Interrupt request from enabled status events
    nxt_s.irq = |(alarm_status & s_ff.alarm_mask)      // R1 R2
              | |(timing_status & s_ff.timing_mask);   // R1 R3

    // Read data captured in the setup phase
    if (setup) begin
      nxt_s.rdata = {24'h000000, rd_mux};
    end

    // Writes take effect at the access edge; counter words ignore writes
    if (access && apb_i.pwrite && hit) begin
      case (idx)
        e1pm_pkg::IDX_ALARM_MASK:  nxt_s.alarm_mask  = apb_i.pwdata[7:0];
        e1pm_pkg::IDX_TIMING_MASK: nxt_s.timing_mask = apb_i.pwdata[7:0];
        e1pm_pkg::IDX_CTRL:        nxt_s.ctrl        = apb_i.pwdata[7:0];
        default:                   nxt_s.ctrl        = s_ff.ctrl; // R18
      endcase
    end
  end

  // State register
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_ff             <= '0;
      s_ff.alarm_mask  <= e1pm_pkg::MASK_RST;
      s_ff.timing_mask <= e1pm_pkg::MASK_RST;
      s_ff.ctrl        <= e1pm_pkg::CTRL_RST;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // Outputs
  assign prdata                = s_ff.rdata;
  assign pready                = 1'b1;            // No wait states
  assign pslverr               = access & ~hit;
  assign timer_status_flag     = s_ff.tick;       // R6
  assign irq_request           = s_ff.irq;
  assign short_interval_select = s_ff.ctrl[e1pm_pkg::CTRL_SHORT_INTERVAL];
  assign code_violation_select = s_ff.ctrl[e1pm_pkg::CTRL_CODE_VIOLATION];
  assign receive_hdb3_enable   = s_ff.ctrl[e1pm_pkg::CTRL_HDB3_ENABLE];

endmodule // e1pm_counters

// >>> sim/e1pm_counters_props.sv
/* Checker for the e1pm_counters ports: tick flag, interrupt request, control bits, bus.
   Bound to the design top; one clock domain, asynchronous active-low reset. */
module e1pm_counters_props (
  // Clock and reset
  input wire logic                ref_clk,
  input wire logic                rst_n,
  // Bus
  input wire e1pm_pkg::e1pm_apb_t apb_i,
  input wire logic [31:0]         prdata,
  input wire logic                pslverr,
  // Framer side
  input wire logic                tick_one_second,
  input wire logic                tick_short,
  input wire logic [7:0]          alarm_status,
  input wire logic [7:0]          timing_status,
  input wire logic                timer_status_flag,
  input wire logic                irq_request,
  input wire logic                short_interval_select,
  input wire logic                code_violation_select,
  input wire logic                receive_hdb3_enable
);
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [7:0] am; logic [7:0] tm;
                         logic irq; logic tick; logic wrc;} e1pm_chk_t;
  e1pm_chk_t st_ff, nxt_st;
  logic      acc, wr;
  // Access phase decode
  assign acc = apb_i.psel && apb_i.penable;
  assign wr = acc && apb_i.pwrite;
  // Shadow masks, expected request, selected tick
  always_comb begin
    nxt_st = st_ff;
    nxt_st.irq = |(alarm_status & st_ff.am) || |(timing_status & st_ff.tm);
    nxt_st.tick = short_interval_select ? tick_short : tick_one_second;
    nxt_st.wrc = wr && apb_i.paddr == 12'h060;
    if (wr && apb_i.paddr == 12'h058) nxt_st.am = apb_i.pwdata[7:0];
    if (wr && apb_i.paddr == 12'h05c) nxt_st.tm = apb_i.pwdata[7:0];
  end
  // Registered copy
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) st_ff <= '0;
    else st_ff <= nxt_st;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence s_ctrl_wr;
    wr && apb_i.paddr == 12'h060;
  endsequence
  a_flag_on_tick: assert property (nxt_st.tick |=> timer_status_flag)
    else $error("No timer flag after tick");
  a_flag_only_tick: assert property (timer_status_flag |-> st_ff.tick)
    else $error("Timer flag without tick");
  a_irq_level: assert property (irq_request == st_ff.irq)
    else $error("Interrupt request wrong");
  a_irq_quiet: assert property ((~|{alarm_status, timing_status}) [*2] |=> !irq_request)
    else $error("Interrupt without event");
  a_ctrl_bits: assert property (s_ctrl_wr |=> short_interval_select == $past(apb_i.pwdata[7])
    && code_violation_select == $past(apb_i.pwdata[6])
    && receive_hdb3_enable == $past(apb_i.pwdata[2])) else $error("Control bits wrong");
  a_ctrl_hold: assert property ($changed(code_violation_select) |-> st_ff.wrc)
    else $error("Mode changed without write");
  a_count_mapped: assert property (acc && apb_i.paddr < 12'h018 && apb_i.paddr[1:0] == 2'b00
    |-> !pslverr) else $error("Counter access refused");
  a_read_byte: assert property (acc && !apb_i.pwrite |-> prdata[31:8] == 24'h000000)
    else $error("Upper read bits not zero");
endmodule // e1pm_counters_props
bind e1pm_counters e1pm_counters_props u_props (.ref_clk, .rst_n, .apb_i, .prdata, .pslverr,
  .tick_one_second, .tick_short, .alarm_status, .timing_status, .timer_status_flag,
  .irq_request, .short_interval_select, .code_violation_select, .receive_hdb3_enable);

// >>> sim/e1pm_host.sv
/* Host model: an APB master issuing single transfers for the bench.
   Assumes the slave answers with pready; it waits as long as that takes. */
module e1pm_host (
  // Clock and slave answer
  input  wire logic           ref_clk,
  input  wire logic           pready,
  input  wire logic [31:0]    prdata,
  input  wire logic           pslverr,
  // Request to the slave
  output e1pm_pkg::e1pm_apb_t apb_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle bus from time zero
  initial apb_o = '0;
  // Setup, then access held until pready is sampled high
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
    @(posedge ref_clk);
    apb_o <= '{1'b1, 1'b0, w, a, wd};
    @(posedge ref_clk);
    apb_o.penable <= 1'b1;
    do @(posedge ref_clk); while (!pready);
    rd = prdata;
    err = pslverr;
    apb_o <= '{1'b0, 1'b0, w, a, wd};
  endtask
endmodule // e1pm_host

// >>> sim/e1pm_counters_bench.sv
/* Bench for e1pm_counters: host model on APB, framer pulses and line bits.
   An integer model predicts every read; one 25 MHz clock. */
module e1pm_counters_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0, rst_n = 1'b0, rx_line_clk = 1'b0, rx_pos = 1'b0, rx_neg = 1'b0;
  logic tick_one_second = 1'b0, tick_short = 1'b0, pready, pslverr, timer_status_flag;
  logic [4:0] err_in = 5'h00;
  logic [7:0] alarm_status = 8'h00, timing_status = 8'h00;
  logic [31:0] prdata, d, seed = 32'h1c51;
  logic e, irq_request;
  e1pm_pkg::e1pm_apb_t apb;
  int bad_count = 0, cmp_count = 0, lastm = 0, lastb = 0, zr = 0, cvm = 0, hdb = 0;
  int live[4] = '{0, 0, 0, 0}, snap[4] = '{0, 0, 0, 0}, maxv[4] = '{65535, 1023, 4095, 1023};
  // Clock
  always #20 ref_clk = ~ref_clk;
  // Host model and design
  e1pm_host host (.ref_clk, .pready, .prdata, .pslverr, .apb_o(apb));
  e1pm_counters dut (.ref_clk, .rst_n, .apb_i(apb), .prdata, .pready, .pslverr, .rx_line_clk,
    .rx_pos, .rx_neg, .tick_one_second, .tick_short, .frame_sync_loss(err_in[3]),
    .crc_mf_sync_loss(err_in[4]), .crc_word_error(err_in[0]), .fas_word_error(err_in[1]),
    .ebit_error(err_in[2]), .alarm_status, .timing_status, .timer_status_flag, .irq_request,
    .short_interval_select(), .code_violation_select(), .receive_hdb3_enable());
  // Random source
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction
  // Compare and count
  task automatic check(input logic [32:0] g, input logic [32:0] x);
    cmp_count++;
    if (g !== x) begin
      bad_count++;
      $display("Error at %0t: got %h, expected %h", $time, g, x);
    end
  endtask
  // Register access helpers
  task automatic rd_chk(input int i, input int x);
    host.xfer(1'b0, 12'(i * 4), 32'h0, d, e);
    check({e, d}, {1'b0, 32'(x)});
  endtask
  task automatic wr(input int i, input logic [31:0] v);
    host.xfer(1'b1, 12'(i * 4), v, d, e);
  endtask
  task automatic cnt(input int i, input bit en);
    if (en && live[i] < maxv[i]) live[i]++;
  endtask
  // One cycle of error pulses and sync levels
  task automatic pulse(input logic [31:0] r);
    @(posedge ref_clk);
    err_in <= {r[4:3], r[2] & ~r[3] & ~r[4], r[1] & ~r[4], r[0]};
    cnt(1, r[0] && !r[3] && !r[4]);
    cnt(2, r[1] && !r[3] && !r[4]);
    cnt(3, r[2] && !r[3] && !r[4]);
  endtask
  // Interval tick; flag only when this tick is the selected one
  task automatic tick(input bit s, input bit hit);
    @(posedge ref_clk);
    tick_short <= s;
    tick_one_second <= !s;
    @(posedge ref_clk);
    tick_short <= 1'b0;
    tick_one_second <= 1'b0;
    @(negedge ref_clk);
    check({32'h0, timer_status_flag}, {32'h0, hit});
    if (hit) begin
      snap = live;
      live = '{0, 0, 0, 0};
    end
  endtask
  // All counter words from one snapshot
  task automatic rd_all();
    rd_chk(0, snap[0] >> 8);
    rd_chk(1, snap[0] & 255);
    rd_chk(2, (snap[2] >> 6 << 2) | (snap[1] >> 8));
    rd_chk(3, snap[1] & 255);
    rd_chk(4, ((snap[2] & 63) << 2) | (snap[3] >> 8));
    rd_chk(5, snap[3] & 255);
  endtask
  // One line bit: 0 space, 1 positive mark, 2 negative mark
  task automatic send_bit(input int m);
    @(posedge ref_clk);
    rx_pos <= (m == 1);
    rx_neg <= (m == 2);
    repeat (5) @(posedge ref_clk);
    rx_line_clk <= 1'b1;
    repeat (4) @(posedge ref_clk);
    rx_line_clk <= 1'b0;
    repeat (3) @(posedge ref_clk);
    if (m == 0) zr++;
    else begin
      if (m == lastm) begin
        if (cvm != 0) cnt(0, m == lastb);
        else cnt(0, !(hdb != 0 && zr >= 2));
        lastb = m;
      end
      lastm = m;
      zr = 0;
    end
  endtask
  // Verdict
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Watchdog
  initial begin
    repeat (40000) @(posedge ref_clk);
    bad_count++;
    stop_test();
  end
  // Main sequence
  initial begin
    logic [7:0] st;
    int rg[9] = '{0, 1, 2, 3, 4, 5, 22, 23, 24};
    logic [7:0] md[3] = '{8'h00, 8'h04, 8'hc4};
    int pat[5] = '{1, 0, 0, 0, 1};
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    foreach (rg[i]) begin
      if (i < 6) wr(rg[i], 32'hff);
      rd_chk(rg[i], 0);
    end
    host.xfer(1'b0, 12'h070, 32'h0, d, e);
    check({e, d}, {1'b1, 32'h0});
    // Walk each mask bit against its event
    for (int b = 0; b < 16; b++) begin
      if (b == 8) wr(22, 32'h0);
      wr(22 + b / 8, 32'h1 << (b % 8));
      for (int v = 0; v < 2; v++) begin
        st = 8'(rnd());
        st[b % 8] = v[0];
        alarm_status <= st;
        timing_status <= st;
        repeat (3) @(posedge ref_clk);
        check({32'h0, irq_request}, {32'h0, v[0]});
      end
    end
    // Quiet status with a mask still open must drop the request
    alarm_status <= 8'h00;
    timing_status <= 8'h00;
    repeat (3) @(posedge ref_clk);
    check({32'h0, irq_request}, 33'h0);
    // Pulse counters, long interval; a short tick is ignored
    wr(24, 32'h0);
    repeat (40) pulse(rnd());
    pulse(0);
    tick(1'b1, 1'b0);
    tick(1'b0, 1'b1);
    rd_all();
    // Line violations in three modes while sync is lost
    pulse(32'h18);
    foreach (md[i]) begin
      wr(24, {24'h0, md[i]});
      rd_chk(24, md[i]);
      cvm = md[i][6];
      hdb = md[i][2];
      foreach (pat[j]) send_bit(pat[j]);
      repeat (40) send_bit(rnd() % 3);
      tick(md[i][7], 1'b1);
      rd_all();
    end
    tick(1'b1, 1'b1);
    rd_all();
    repeat (4100) pulse(32'h7);
    pulse(0);
    tick(1'b1, 1'b1);
    rd_all();
    stop_test();
  end
endmodule // e1pm_counters_bench
